// ==== input_decoder_params.svh ====
// function codes, field widths and reset values of the digital input decoder
// assumes inclusion from the package and design modules by bare name
`ifndef INPUT_DECODER_PARAMS_SVH
`define INPUT_DECODER_PARAMS_SVH

`define TERMINAL_COUNT   9
`define CODE_WIDTH       5
`define FUNC_COUNT       26
`define FREQ_WIDTH       16
`define CODE_SPEED0      5'h00
`define CODE_RUNLATCH    5'h03
`define CODE_COAST       5'h04
`define CODE_CLEAR       5'h05
`define CODE_EXTFAULT    5'h06
`define CODE_INCHING     5'h07
`define CODE_FREQSEL     5'h08
`define CODE_BRAKE       5'h09
`define CODE_SPEEDUP     5'h0a
`define CODE_SPEEDDOWN   5'h0b
`define CODE_EDIT        5'h0c
`define CODE_INVERSE     5'h0d
`define CODE_INTERLOCK   5'h0e
`define CODE_LINK        5'h0f
`define CODE_GENERAL     5'h10
`define CODE_MOTOR1      5'h11
`define CODE_MOTORBIT0   5'h16
`define CODE_PARITY      5'h19
`define CODE_NONE        5'h1f
`define FUNCS_RESET      26'h0000000

`endif

// ==== input_decoder_pkg.sv ====
// types shared by the digital input decoder modules
// assumes the params header sits in the same folder
`include "input_decoder_params.svh"
package input_decoder_pkg;

	typedef logic [`CODE_WIDTH-1:0]  func_code_t;
	typedef logic [`FUNC_COUNT-1:0]  func_vec_t;
	typedef logic [`FREQ_WIDTH-1:0]  freq_t;

	typedef enum logic [1:0] {ST_STOP, ST_START, ST_RUN, ST_TRIP} run_state_t;

	typedef enum logic [1:0] {FS_METHOD, FS_PRESET, FS_INCHING} freq_src_t;

	typedef struct packed {
		logic [`TERMINAL_COUNT-1:0] syncA;
		logic [`TERMINAL_COUNT-1:0] syncB;
	} sync_state_t;

	typedef struct packed {
		func_vec_t  funcs;
		run_state_t runState;
		logic       fwdLatch;
		logic       revLatch;
		logic       overheat;
		logic       alarm;
		logic       clearSeen;
		logic       runForward;
		logic       runReverse;
		logic       outputOn;
		logic       startFromBase;
		logic       rampUp;
		logic       rampDown;
		logic       useMethod2;
		freq_src_t  freqSource;
		logic [2:0] presetIndex;
		freq_t      freqTarget;
		logic       brakeRequest;
		logic       editPermit;
		logic       inverseAnalogSelect;
		logic       powerFailInterlock;
		logic       linkAccept;
		logic       generalReadableInput;
		logic [4:0] motorOneHot;
		logic [2:0] motorNumberBits;
		logic       motorParity;
	} dec_state_t;

endpackage : input_decoder_pkg

// ==== input_synchronizer.sv ====
// two-stage synchroniser for the contact input terminals
// assumes terminal levels are already clean of contact bounce
`timescale 1ns/1ps
`include "input_decoder_params.svh"
module input_synchronizer
	import input_decoder_pkg::*;
(
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	input  wire logic [`TERMINAL_COUNT-1:0] rawIn,
	output logic      [`TERMINAL_COUNT-1:0] syncOut
);

	sync_state_t state;
	sync_state_t next_state;

	// first stage feeds only the second stage
	always_comb
	begin
		next_state.syncA = rawIn;
		next_state.syncB = state.syncA;
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= '0;
		else
			state <= next_state;
	end

	assign syncOut = state.syncB;

endmodule : input_synchronizer

// ==== digital_input_function_decoder.sv ====
// maps nine contact terminals onto drive commands by function code
// assumes function codes and frequencies are held stable by the caller
`timescale 1ns/1ps
`include "input_decoder_params.svh"
module digital_input_function_decoder
	import input_decoder_pkg::*;
(
	input  wire logic                       core_clk,
	input  wire logic                       reset_n,
	input  wire logic [`TERMINAL_COUNT-1:0] inputTerminal,
	input  wire logic [`TERMINAL_COUNT*`CODE_WIDTH-1:0] terminalFunctionCode,
	input  wire logic                       forwardRunRequest,
	input  wire logic                       reverseRunRequest,
	input  wire logic                       editRequest,
	input  wire logic                       linkRunForward,
	input  wire logic                       linkRunReverse,
	input  wire logic                       linkFreqValid,
	input  wire logic [`FREQ_WIDTH-1:0]     linkFrequency,
	input  wire logic [7*`FREQ_WIDTH-1:0]   presetFrequency,
	input  wire logic [`FREQ_WIDTH-1:0]     inchingFrequency,
	input  wire logic [`FREQ_WIDTH-1:0]     methodFrequency,
	output logic                            runForward,
	output logic                            runReverse,
	output logic                            outputOn,
	output logic                            startFromBase,
	output logic                            externalOverheatAlarm,
	output logic                            alarmOutput,
	output logic                            rampUp,
	output logic                            rampDown,
	output logic                            useMethod2,
	output logic [1:0]                      freqSource,
	output logic [2:0]                      presetIndex,
	output logic [`FREQ_WIDTH-1:0]          freqTarget,
	output logic                            brakeRequest,
	output logic                            editPermit,
	output logic                            inverseAnalogSelect,
	output logic                            powerFailInterlock,
	output logic                            linkAccept,
	output logic                            generalReadableInput,
	output logic [4:0]                      motorSelect,
	output logic [2:0]                      motorNumberBits,
	output logic                            motorParity
);

	logic [`TERMINAL_COUNT-1:0] syncIn;
	func_vec_t                  rawFuncs;
	func_vec_t                  assigned;
	dec_state_t                 state;
	dec_state_t                 next_state;

	// terminal levels into the core clock
	input_synchronizer syncUnit (
		.core_clk (core_clk),
		.reset_n  (reset_n),
		.rawIn    (inputTerminal),
		.syncOut  (syncIn)
	);

	// per-function OR over terminals carrying that code
	genvar f;
	generate
		for (f = 0; f < `FUNC_COUNT; f++)
		begin : gFunc
			logic [`TERMINAL_COUNT-1:0] hit;
			for (genvar t = 0; t < `TERMINAL_COUNT; t++)
			begin : gTerm
				assign hit[t] = terminalFunctionCode[t*`CODE_WIDTH +:
					`CODE_WIDTH] == `CODE_WIDTH'(f);
			end
			assign assigned[f] = |hit;
			assign rawFuncs[f] = |(hit & syncIn);
		end
	endgenerate

	// decoded commands, run sequencing and frequency selection
	always_comb
	begin
		logic       coast;
		logic       clearIn;
		logic       faultOk;
		logic       runFwd;
		logic       runRev;
		logic       anyRun;
		logic [2:0] idx;
		next_state = state;
		idx = 3'h0;
		next_state.funcs = rawFuncs;
		// unassigned external fault reads closed, registered with the rest
		next_state.funcs[`CODE_EXTFAULT] = rawFuncs[`CODE_EXTFAULT] |
			~assigned[`CODE_EXTFAULT];
		coast   = state.funcs[`CODE_COAST];
		clearIn = state.funcs[`CODE_CLEAR];
		faultOk = state.funcs[`CODE_EXTFAULT];
		runFwd = forwardRunRequest |
			(state.funcs[`CODE_LINK] & linkRunForward);
		runRev = reverseRunRequest |
			(state.funcs[`CODE_LINK] & linkRunReverse);
		// three-wire latch: hold while run latch is on
		if (state.funcs[`CODE_RUNLATCH])
		begin
			next_state.fwdLatch = state.fwdLatch | runFwd;
			next_state.revLatch = state.revLatch | runRev;
		end
		else
		begin
			next_state.fwdLatch = 1'b0;
			next_state.revLatch = 1'b0;
		end
		runFwd = runFwd | state.fwdLatch;
		runRev = runRev | state.revLatch;
		anyRun = runFwd ^ runRev;
		next_state.runForward = anyRun & runFwd;
		next_state.runReverse = anyRun & runRev;
		next_state.clearSeen = clearIn;
		next_state.startFromBase = 1'b0;
		case (state.runState)
			ST_STOP:
			begin
				if (!faultOk)
					next_state.runState = ST_STOP;
				else if (anyRun && !coast)
					next_state.runState = ST_START;
			end
			ST_START:
			begin
				next_state.startFromBase = 1'b1;
				next_state.runState = ST_RUN;
			end
			ST_RUN:
			begin
				if (!faultOk)
				begin
					next_state.overheat = 1'b1;
					next_state.alarm = 1'b1;
					next_state.runState = ST_TRIP;
				end
				else if (coast || !anyRun)
					next_state.runState = ST_STOP;
			end
			ST_TRIP:
			begin
				if (clearIn)
					next_state.alarm = 1'b0;
				if (state.clearSeen && !clearIn)
				begin
					next_state.overheat = 1'b0;
					next_state.runState = ST_STOP;
				end
			end
			default: next_state.runState = ST_STOP;
		endcase
		next_state.outputOn = (next_state.runState == ST_RUN) ||
			(next_state.runState == ST_START);
		// ramp requests, exclusive, only while exactly one run direction is commanded
		next_state.rampUp = anyRun & state.funcs[`CODE_SPEEDUP] &
			~state.funcs[`CODE_SPEEDDOWN];
		next_state.rampDown = anyRun & state.funcs[`CODE_SPEEDDOWN] &
			~state.funcs[`CODE_SPEEDUP];
		// frequency source priority: inching, preset, method
		idx = {state.funcs[2], state.funcs[1], state.funcs[0]};
		next_state.presetIndex = idx;
		next_state.useMethod2 = state.funcs[`CODE_FREQSEL];
		if (state.funcs[`CODE_INCHING] && anyRun)
		begin
			next_state.freqSource = FS_INCHING;
			next_state.freqTarget = inchingFrequency;
		end
		else if (idx != 3'h0)
		begin
			next_state.freqSource = FS_PRESET;
			next_state.freqTarget =
				presetFrequency[(idx - 3'h1) * `FREQ_WIDTH +: `FREQ_WIDTH];
		end
		else if (state.funcs[`CODE_LINK] && linkFreqValid)
		begin
			next_state.freqSource = FS_METHOD;
			next_state.freqTarget = linkFrequency;
		end
		else
		begin
			next_state.freqSource = FS_METHOD;
			next_state.freqTarget = methodFrequency;
		end
		// pass-through commands, edit permit also gated by editRequest
		next_state.brakeRequest = state.funcs[`CODE_BRAKE];
		next_state.editPermit = editRequest &
			(!assigned[`CODE_EDIT] || state.funcs[`CODE_EDIT]);
		next_state.inverseAnalogSelect = state.funcs[`CODE_INVERSE];
		next_state.powerFailInterlock = state.funcs[`CODE_INTERLOCK];
		next_state.linkAccept = state.funcs[`CODE_LINK];
		next_state.generalReadableInput = state.funcs[`CODE_GENERAL];
		next_state.motorOneHot = state.funcs[`CODE_MOTOR1 +: 5];
		next_state.motorNumberBits = state.funcs[`CODE_MOTORBIT0 +: 3];
		next_state.motorParity = state.funcs[`CODE_PARITY];
	end

	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			state <= '0;
		else
			state <= next_state;
	end

	// every output straight from the state register
	assign runForward            = state.runForward;
	assign runReverse            = state.runReverse;
	assign outputOn              = state.outputOn;
	assign startFromBase         = state.startFromBase;
	assign externalOverheatAlarm = state.overheat;
	assign alarmOutput           = state.alarm;
	assign rampUp                = state.rampUp;
	assign rampDown              = state.rampDown;
	assign useMethod2            = state.useMethod2;
	assign freqSource            = state.freqSource;
	assign presetIndex           = state.presetIndex;
	assign freqTarget            = state.freqTarget;
	assign brakeRequest          = state.brakeRequest;
	assign editPermit            = state.editPermit;
	assign inverseAnalogSelect   = state.inverseAnalogSelect;
	assign powerFailInterlock    = state.powerFailInterlock;
	assign linkAccept            = state.linkAccept;
	assign generalReadableInput  = state.generalReadableInput;
	assign motorSelect           = state.motorOneHot;
	assign motorNumberBits       = state.motorNumberBits;
	assign motorParity           = state.motorParity;

endmodule : digital_input_function_decoder

// ==== contact_switches.sv ====
// contact bank wired to the nine input terminals
// assumes the bench sets contact states at the falling clock edge
`timescale 1ns/1ps
module contact_switches
(
	input  wire logic [8:0] closeReq,
	output logic      [8:0] inputTerminal
);
	// a closed contact pulls its terminal high, an open one reads low
	assign inputTerminal = closeReq;
endmodule : contact_switches

// ==== decoder_checker_assertions.sv ====
// concurrent checks on the input decoder's ports
// assumes it is bound onto the decoder module
`timescale 1ns/1ps
module decoder_checker
(
	input wire logic        core_clk,
	input wire logic        reset_n,
	input wire logic [44:0] terminalFunctionCode,
	input wire logic [15:0] inchingFrequency,
	input wire logic        runForward,
	input wire logic        runReverse,
	input wire logic        outputOn,
	input wire logic        startFromBase,
	input wire logic        externalOverheatAlarm,
	input wire logic        rampUp,
	input wire logic        rampDown,
	input wire logic [1:0]  freqSource,
	input wire logic [2:0]  presetIndex,
	input wire logic [15:0] freqTarget,
	input wire logic        generalReadableInput
);
	// true when any terminal carries code c
	function automatic logic has(logic [44:0] v, logic [4:0] c);
		has = 1'b0;
		for (int t = 0; t < 9; t++)
			has |= v[5*t+:5] == c;
	endfunction : has
	default clocking dc @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	// code absent long enough to have left the decode pipe
	sequence s_gone(c);
		!has(terminalFunctionCode, c) [*3];
	endsequence
	sequence s_pulse;
		startFromBase ##1 !startFromBase;
	endsequence
	property p_start;
		$rose(outputOn) |=> s_pulse;
	endproperty
	a_start: assert property (p_start) else $error("no start pulse");
	property p_ramp;
		rampUp |-> !rampDown;
	endproperty
	a_ramp: assert property (p_ramp) else $error("both ramps");
	property p_dir;
		runForward |-> !runReverse;
	endproperty
	a_dir: assert property (p_dir) else $error("both directions");
	property p_trip;
		$rose(externalOverheatAlarm) |-> !outputOn;
	endproperty
	a_trip: assert property (p_trip) else $error("output on at trip");
	property p_preset;
		freqSource == 2'd1 |-> presetIndex != 3'd0;
	endproperty
	a_preset: assert property (p_preset) else $error("preset at zero");
	property p_inch;
		freqSource == 2'd2 |-> freqTarget == inchingFrequency;
	endproperty
	a_inch: assert property (p_inch) else $error("inching freq");
	property p_unused;
		s_gone(5'h10) |-> !generalReadableInput;
	endproperty
	a_unused: assert property (p_unused) else $error("unset input on");
	property p_nofault;
		s_gone(5'h06) |-> !$rose(externalOverheatAlarm);
	endproperty
	a_nofault: assert property (p_nofault) else $error("phantom trip");
endmodule : decoder_checker
bind digital_input_function_decoder decoder_checker sva (.core_clk,
	.reset_n, .terminalFunctionCode, .inchingFrequency, .runForward,
	.runReverse, .outputOn, .startFromBase, .externalOverheatAlarm, .rampUp,
	.rampDown, .freqSource, .presetIndex, .freqTarget,
	.generalReadableInput);

// ==== tb.sv ====
// self-checking bench for the input decoder
// assumes decoder, checker and contact model are compiled first
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0, reset_n = 1'b0, editRequest = 1'b1;
	logic forwardRunRequest = 1'b0, reverseRunRequest = 1'b0;
	logic linkRunForward = 1'b1, linkRunReverse = 1'b0, linkFreqValid;
	logic [8:0]   closeReq = 9'h010, inputTerminal;
	logic [44:0]  terminalFunctionCode;
	logic [15:0]  linkFrequency, inchingFrequency, methodFrequency, freqTarget;
	logic [111:0] presetFrequency;
	logic runForward, runReverse, outputOn, startFromBase, alarmOutput;
	logic externalOverheatAlarm, rampUp, rampDown, useMethod2, motorParity;
	logic brakeRequest, editPermit, inverseAnalogSelect, linkAccept;
	logic powerFailInterlock, generalReadableInput;
	logic [1:0]   freqSource;
	logic [2:0]   presetIndex, motorNumberBits, mix;
	logic [4:0]   motorSelect;
	logic [2:0]   alarms, runFlags;
	// alarm and run flags gathered for compact checks
	assign alarms   = {externalOverheatAlarm, alarmOutput, outputOn};
	assign runFlags = {outputOn, runForward, runReverse};
	int           num_errors, cmp_count;
	contact_switches bank (.closeReq, .inputTerminal);
	digital_input_function_decoder dut (.core_clk, .reset_n, .inputTerminal,
		.terminalFunctionCode, .forwardRunRequest, .reverseRunRequest,
		.editRequest, .linkRunForward, .linkRunReverse, .linkFreqValid,
		.linkFrequency, .presetFrequency, .inchingFrequency, .methodFrequency,
		.runForward, .runReverse, .outputOn, .startFromBase,
		.externalOverheatAlarm, .alarmOutput, .rampUp, .rampDown, .useMethod2,
		.freqSource, .presetIndex, .freqTarget, .brakeRequest, .editPermit,
		.inverseAnalogSelect, .powerFailInterlock, .linkAccept,
		.generalReadableInput, .motorSelect, .motorNumberBits, .motorParity);
	// frequency expected for a preset index
	function automatic logic [15:0] expFreq(logic [2:0] i);
		return i == 3'd0 ? methodFrequency : presetFrequency[16*(i-1)+:16];
	endfunction : expFreq
	// decoded output that a given function code drives
	function automatic logic seen(int c);
		logic [25:0] v;
		v = {motorParity, motorNumberBits, motorSelect, generalReadableInput,
			linkAccept, powerFailInterlock, inverseAnalogSelect, editPermit,
			rampDown, rampUp, brakeRequest, useMethod2, 8'h00};
		return v[c];
	endfunction : seen
	task automatic chk(string n, logic [15:0] e, logic [15:0] s);
		cmp_count++;
		if (s !== e)
		begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic w(int n);
		repeat (n) @(negedge core_clk);
	endtask : w
	task automatic stop_test();
		$display("checks %0d errors %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : stop_test
	// clock and hang guard
	initial
		forever #25 core_clk = ~core_clk;
	initial
	begin
		repeat (3000) @(posedge core_clk);
		num_errors++;
		stop_test();
	end
	// main sequence, inputs changed at falling edges only
	initial
	begin
		void'($urandom(32'h6c6d9be6));
		linkFreqValid = 1'($urandom);
		linkFrequency = 16'($urandom);
		inchingFrequency = 16'($urandom);
		methodFrequency = 16'($urandom);
		presetFrequency = 112'({$urandom, $urandom, $urandom, $urandom});
		mix = 3'($urandom);
		terminalFunctionCode = {5'h1f, 5'h03, 5'h07, 5'h04, 5'h06,
			5'h05, 5'h02, 5'h01, 5'h00};
		w(6);
		reset_n = 1'b1;
		w(6);
		chk("outputOn", 16'd0, 16'(outputOn));
		// every preset index, shuffled
		for (int k = 0; k < 8; k++)
		begin
			closeReq[2:0] = 3'(k) ^ mix;
			w(6);
			chk("presetIndex", 16'(closeReq[2:0]), 16'(presetIndex));
			chk("freqTarget", expFreq(closeReq[2:0]), freqTarget);
		end
		closeReq[2:0] = 3'd0;
		forwardRunRequest = 1'b1;
		w(3);
		chk("run", 16'd3, 16'({outputOn, runForward}));
		closeReq[6] = 1'b1;
		w(6);
		chk("freqTarget", inchingFrequency, freqTarget);
		closeReq[6] = 1'b0;
		// spare terminal walks every single-line function code
		closeReq[8] = 1'b1;
		for (int c = 8; c < 26; c++)
		begin
			terminalFunctionCode[40+:5] = 5'(c);
			w(6);
			chk("probe on", 16'd1, 16'(seen(c)));
			closeReq[8] = 1'b0;
			w(6);
			chk("probe off", 16'd0, 16'(seen(c)));
			closeReq[8] = 1'b1;
			terminalFunctionCode[40+:5] = 5'h1f;
			w(6);
			chk("probe unset", 16'(c == 12), 16'(seen(c)));
		end
		closeReq[5] = 1'b1;
		w(6);
		chk("coast", 16'd0, 16'({alarmOutput, outputOn}));
		closeReq[5] = 1'b0;
		w(7);
		chk("resume", 16'd1, 16'(outputOn));
		closeReq[4] = 1'b0;
		w(6);
		chk("trip", 16'd6, 16'(alarms));
		closeReq[4] = 1'b1;
		closeReq[3] = 1'b1;
		w(6);
		chk("clear", 16'd4, 16'(alarms));
		closeReq[3] = 1'b0;
		w(7);
		chk("restart", 16'd1, 16'(alarms));
		// external fault unassigned while its contact is open: no trip
		closeReq[4] = 1'b0;
		terminalFunctionCode[20+:5] = 5'h1f;
		w(6);
		chk("no fault", 16'd1, 16'(alarms));
		closeReq[4] = 1'b1;
		w(4);
		terminalFunctionCode[20+:5] = 5'h06;
		w(2);
		closeReq[7] = 1'b1;
		w(6);
		forwardRunRequest = 1'b0;
		w(4);
		chk("held", 16'd1, 16'(outputOn));
		closeReq[7] = 1'b0;
		w(7);
		chk("released", 16'd0, 16'(outputOn));
		// reverse alone runs reverse, both directions together stop
		reverseRunRequest = 1'b1;
		w(3);
		chk("reverse", 16'd5, 16'(runFlags));
		forwardRunRequest = 1'b1;
		w(3);
		chk("both", 16'd0, 16'(runFlags));
		stop_test();
	end
endmodule : tb
